// >>> hw/rcs_stats.sv
`timescale 1ns/10ps
module rcs_stats
    import rcs_pkg::*;
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic [1:0] hresp,
    // Checksum engine result.
    input wire rcs_event_t ce_result
);

    // ********************************************************************
    // State and decoding helpers
    // ********************************************************************

    // Every register of the block lives in one packed struct; one combinational
    // process works out the next copy and one clocked process stores it.
    // Whole state of the block.
    typedef struct packed {
        // All counter values, in the index order of the package.
        logic [RCS_NCNT-1:0][31:0] cnt;
        // Control bits held from the last control write.
        logic freeze;
        logic stop_roll;
        logic rd_clr_en;
        // Transfer captured in its address phase, acted on in the next cycle.
        logic pend;
        logic pend_wr;
        logic pend_lane0;
        logic [RCS_AW-1:0] pend_addr;
        // Registered bus answer.
        logic hreadyout;
        logic [31:0] hrdata;
        logic [1:0] hresp;
    } rcs_state_t;

    // Current and next state.
    rcs_state_t st_reg;
    rcs_state_t st_next;
    // Amount to add to each counter this cycle.
    logic [RCS_NCNT-1:0][31:0] inc;
    // Counters cleared by a read this cycle.
    logic [RCS_NCNT-1:0] clr;
    // Counter reset request from a control write.
    logic rst_pulse;
    // Data phase of a control write.
    logic ctrl_wr;
    // Address phase accepted this cycle.
    logic accept;
    // Payload was checked by the engine on a good datagram.
    logic pay_ok;
    // Byte lengths widened to counter width.
    logic [31:0] ip_bytes;
    logic [31:0] seg_bytes;

    // Returns true when the address selects counter idx.
    function automatic logic cnt_hit(input logic [RCS_AW-1:0] addr, input int idx);
        cnt_hit = (addr == RCS_CNT_OFS[idx]);
    endfunction

    // Drive the bus outputs straight from the state flops.
    assign hreadyout = st_reg.hreadyout;
    assign hrdata = st_reg.hrdata;
    assign hresp = st_reg.hresp;

    // ********************************************************************
    // Bus side decode
    // ********************************************************************

    // The slave inserts exactly one wait state per transfer. The address phase
    // is stored, the next cycle holds hreadyout low, and the answer follows.
    // Writes reach only the control word; counter writes finish but change nothing.
    // While a transfer is pending, the data-phase branch below takes priority.
    // An address phase is taken when selected, active and the bus is ready.
    assign accept = hsel && hready && htrans[1];
    // Control writes act in the data phase, where hwdata is valid.
    assign ctrl_wr = st_reg.pend && st_reg.pend_wr && (st_reg.pend_addr == RCS_CTRL_OFS);
    // A counter reset is a one-shot action; the bit is never stored.
    assign rst_pulse = ctrl_wr && hwdata[RCS_CTRL_RESET];

    // Marks counters whose lane zero is read while reset-on-read is on.
    // A read that does not address the lowest byte lane leaves the counter alone.
    always_comb begin
        for (int i = 0; i < RCS_NCNT; i++) begin
            clr[i] = st_reg.pend && !st_reg.pend_wr && st_reg.pend_lane0 &&
                st_reg.rd_clr_en && cnt_hit(st_reg.pend_addr, i);
        end
    end

    // ********************************************************************
    // Datagram classification
    // ********************************************************************

    // Each result is classified in one cycle; several counters may move at once.
    // Fragmented or bad-header datagrams never reach the transport counters,
    // since their payload checksum cannot be judged.
    // Widen the lengths carried by the result.
    assign ip_bytes = 32'(ce_result.ip_len);
    assign seg_bytes = 32'(ce_result.seg_len);
    // Fragments are not checked, so only whole good datagrams carry a verdict.
    assign pay_ok = ce_result.valid && !ce_result.hdr_err && !ce_result.frag &&
        (ce_result.payload != RCS_PL_NONE);

    // Works out how much each counter gains from this cycle's result.
    always_comb begin
        // Version of the datagram, qualified by valid.
        logic v4;
        logic v6;
        // Header verdict and checked payload per protocol.
        logic good;
        logic udp;
        logic tcp;
        logic icmp;
        // Classes that steer counts away from the usual counters.
        logic v4_uoff;
        logic v6_nopay;
        v4 = ce_result.valid && ce_result.is_ipv4;
        v6 = ce_result.valid && ce_result.is_ipv6;
        good = !ce_result.hdr_err;
        udp = pay_ok && (ce_result.payload == RCS_PL_UDP);
        tcp = pay_ok && (ce_result.payload == RCS_PL_TCP);
        icmp = pay_ok && (ce_result.payload == RCS_PL_ICMP);
        v4_uoff = v4 && udp && ce_result.udp_csum_off;
        // Extension headers leave the payload unreached in IPv6.
        v6_nopay = v6 && (ce_result.payload == RCS_PL_NONE || ce_result.frag);
        // Nothing moves unless a branch below claims the counter.
        inc = '0;
        // IPv4 frames whose payload is RCS_PL_NONE.
        if (v4 && ce_result.payload == RCS_PL_NONE) begin
            inc[I_V4_NOPAY_F] = RCS_FRAME_INC;
            inc[I_V4_NOPAY_B] = ip_bytes;
        end
        // Good fragmented IPv4 datagrams.
        if (v4 && good && ce_result.frag) begin
            inc[I_V4_FRAG_F] = RCS_FRAME_INC;
            inc[I_V4_FRAG_B] = ip_bytes;
        end
        // UDP over IPv4 with the checksum switched off.
        if (v4_uoff) begin
            inc[I_V4_UOFF_F] = RCS_FRAME_INC;
            inc[I_V4_UOFF_B] = seg_bytes;
        end
        // IPv4 header errors.
        if (v4 && !good) begin
            inc[I_V4_HERR_B] = ip_bytes;
        end
        // Good IPv4 datagrams with a checked payload.
        if (v4 && pay_ok) begin
            inc[I_V4_GOOD_B] = ip_bytes;
        end
        // Good IPv6 datagrams with a checked payload.
        if (v6 && pay_ok) begin
            inc[I_V6_GOOD_F] = RCS_FRAME_INC;
            inc[I_V6_GOOD_B] = ip_bytes;
        end
        // IPv6 header errors.
        if (v6 && !good) begin
            inc[I_V6_HERR_F] = RCS_FRAME_INC;
            inc[I_V6_HERR_B] = ip_bytes;
        end
        // IPv6 datagrams without a reachable payload.
        if (v6_nopay) begin
            inc[I_V6_NOPAY_F] = RCS_FRAME_INC;
            inc[I_V6_NOPAY_B] = ip_bytes;
        end
        // UDP results; checksum-off datagrams are counted elsewhere.
        if (udp && !v4_uoff) begin
            if (ce_result.csum_err) begin
                inc[I_UDP_ERR_F] = RCS_FRAME_INC;
                inc[I_UDP_ERR_B] = seg_bytes;
            end else begin
                inc[I_UDP_GOOD_F] = RCS_FRAME_INC;
                inc[I_UDP_GOOD_B] = seg_bytes;
            end
        end
        // TCP results.
        if (tcp) begin
            if (ce_result.csum_err) begin
                inc[I_TCP_ERR_F] = RCS_FRAME_INC;
                inc[I_TCP_ERR_B] = seg_bytes;
            end else begin
                inc[I_TCP_GOOD_F] = RCS_FRAME_INC;
                inc[I_TCP_GOOD_B] = seg_bytes;
            end
        end
        // ICMP results.
        if (icmp) begin
            if (ce_result.csum_err) begin
                inc[I_ICMP_ERR_F] = RCS_FRAME_INC;
                inc[I_ICMP_ERR_B] = seg_bytes;
            end else begin
                inc[I_ICMP_GOOD_F] = RCS_FRAME_INC;
                inc[I_ICMP_GOOD_B] = seg_bytes;
            end
        end
    end

    // ********************************************************************
    // Next state
    // ********************************************************************

    // Precedence per counter: counter reset, then freeze, then the increment.
    // A read clear feeds the increment path, so a frame landing in the same
    // cycle as the clear is kept rather than lost.
    // Updates counters, control bits and the bus answer.
    always_comb begin
        logic [32:0] sum;
        logic [31:0] base;
        logic [31:0] rd_val;
        sum = '0;
        base = '0;
        rd_val = RCS_RD_ZERO;
        st_next = st_reg;
        // Every transfer is answered OKAY.
        st_next.hresp = RCS_HRESP_OKAY;
        // Counter update, one slot per counter.
        for (int i = 0; i < RCS_NCNT; i++) begin
            // A read clear starts from zero so a same-cycle frame survives.
            base = clr[i] ? RCS_CNT_RESET : st_reg.cnt[i];
            // The sum is one bit wider so that a carry out can be seen.
            sum = {1'b0, base} + {1'b0, inc[i]};
            if (rst_pulse) begin
                st_next.cnt[i] = RCS_CNT_RESET;
            end else if (st_reg.freeze) begin
                st_next.cnt[i] = base;
            end else if (sum[32] && st_reg.stop_roll) begin
                st_next.cnt[i] = RCS_CNT_MAX;
            end else begin
                st_next.cnt[i] = sum[31:0];
            end
        end
        // Read value for the pending address, taken before any clear.
        for (int i = 0; i < RCS_NCNT; i++) begin
            // Offsets are unique, so at most one counter matches.
            if (cnt_hit(st_reg.pend_addr, i)) begin
                rd_val = st_reg.cnt[i];
            end
        end
        // The control word reads back its held bits; the reset bit reads zero.
        if (st_reg.pend_addr == RCS_CTRL_OFS) begin
            rd_val[RCS_CTRL_STOP_ROLL] = st_reg.stop_roll;
            rd_val[RCS_CTRL_RD_CLR] = st_reg.rd_clr_en;
            rd_val[RCS_CTRL_FREEZE] = st_reg.freeze;
        end
        // Bus sequencing: one wait state, then the answer.
        if (st_reg.pend) begin
            // Data phase: finish the transfer.
            st_next.pend = 1'b0;
            st_next.hreadyout = 1'b1;
            if (st_reg.pend_wr) begin
                // Only the control register takes writes; counters are read-only.
                // The counter reset bit acts through rst_pulse and is not kept.
                if (ctrl_wr) begin
                    st_next.stop_roll = hwdata[RCS_CTRL_STOP_ROLL];
                    st_next.rd_clr_en = hwdata[RCS_CTRL_RD_CLR];
                    st_next.freeze = hwdata[RCS_CTRL_FREEZE];
                end
            end else begin
                // Read data stands until the next read completes.
                st_next.hrdata = rd_val;
            end
        end else if (accept) begin
            // Address phase: capture and stall the bus for one cycle.
            st_next.pend = 1'b1;
            st_next.pend_wr = hwrite;
            st_next.pend_addr = haddr[RCS_AW-1:0];
            // Lane zero is addressed when the low address bits are zero.
            st_next.pend_lane0 = (haddr[1:0] == RCS_BYTE_LANE0);
            st_next.hreadyout = 1'b0;
        end
    end

    // Registers the whole state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Reset clears everything, but the bus idles ready.
            st_reg <= '0;
            st_reg.hreadyout <= 1'b1;
        end else begin
            // Normal operation loads the next state.
            st_reg <= st_next;
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************

    // Step assertions compare five chosen counters against their expected step. Cycles with a
    // counter reset, freeze, read clear or a counter at its limit are left out,
    // because other rules govern them there.
    // Helper: counter i may change only by this cycle's increment.
    logic [RCS_NCNT-1:0] free_upd;
    // Helper: counter i would carry out of 32 bits this cycle.
    logic [RCS_NCNT-1:0] wraps;
    always_comb begin
        for (int i = 0; i < RCS_NCNT; i++) begin
            free_upd[i] = !rst_pulse && !st_reg.freeze && !clr[i] &&
                (st_reg.cnt[i] != RCS_CNT_MAX);
            // Carry out of the widened sum.
            wraps[i] = ({1'b0, st_reg.cnt[i]} + {1'b0, inc[i]}) > {1'b0, RCS_CNT_MAX};
        end
    end

    // All checks run on the bus clock and rest while reset is held.
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_udp_off_excl: assert property (
        free_upd[I_UDP_GOOD_F] && ce_result.valid && ce_result.is_ipv4 &&
        ce_result.udp_csum_off && ce_result.payload == RCS_PL_UDP
        |=> st_reg.cnt[I_UDP_GOOD_F] == $past(st_reg.cnt[I_UDP_GOOD_F]))
        else $error("good UDP counter moved on a checksum-off datagram");

    a_v6_ext_nopay: assert property (
        free_upd[I_V6_NOPAY_F] && ce_result.valid && ce_result.is_ipv6 && ce_result.frag
        |=> st_reg.cnt[I_V6_NOPAY_F] == $past(st_reg.cnt[I_V6_NOPAY_F]) + RCS_FRAME_INC)
        else $error("IPv6 extension header datagram not counted as no-payload");

    a_v4_herr_bytes: assert property (
        free_upd[I_V4_HERR_B] && !wraps[I_V4_HERR_B] && ce_result.valid &&
        ce_result.is_ipv4 && ce_result.hdr_err
        |=> st_reg.cnt[I_V4_HERR_B] == $past(st_reg.cnt[I_V4_HERR_B]) + $past(ip_bytes))
        else $error("IPv4 header error bytes did not grow by IP length");

    a_udp_off_bytes: assert property (
        free_upd[I_V4_UOFF_B] && !wraps[I_V4_UOFF_B] && ce_result.valid &&
        ce_result.is_ipv4 && ce_result.udp_csum_off && pay_ok &&
        ce_result.payload == RCS_PL_UDP
        |=> st_reg.cnt[I_V4_UOFF_B] == $past(st_reg.cnt[I_V4_UOFF_B]) + $past(seg_bytes))
        else $error("checksum-off bytes did not grow by segment length");

    a_v6_herr_frame: assert property (
        free_upd[I_V6_HERR_F] && ce_result.valid && ce_result.is_ipv6 && ce_result.hdr_err
        |=> st_reg.cnt[I_V6_HERR_F] == $past(st_reg.cnt[I_V6_HERR_F]) + RCS_FRAME_INC)
        else $error("IPv6 header error frame not counted");

    a_ctrl_reset_all: assert property (
        rst_pulse |=> st_reg.cnt == '0)
        else $error("counter reset left a counter nonzero");

    a_read_clears: assert property (
        clr[I_TCP_GOOD_F] && inc[I_TCP_GOOD_F] == '0 && !st_reg.freeze
        ##1 st_reg.hreadyout
        |-> st_reg.cnt[I_TCP_GOOD_F] == RCS_CNT_RESET &&
            hrdata == $past(st_reg.cnt[I_TCP_GOOD_F]))
        else $error("reset-on-read did not clear or answer the counter");

    a_freeze_holds: assert property (
        st_reg.freeze && !rst_pulse && clr == '0 |=> $stable(st_reg.cnt))
        else $error("a counter changed while frozen");

    a_stop_rollover: assert property (
        st_reg.stop_roll && !rst_pulse && !st_reg.freeze && !clr[I_V4_GOOD_B] &&
        st_reg.cnt[I_V4_GOOD_B] == RCS_CNT_MAX
        |=> st_reg.cnt[I_V4_GOOD_B] == RCS_CNT_MAX)
        else $error("a saturated counter moved");

    a_bus_wait_one: assert property (
        accept && !st_reg.pend |=> !hreadyout ##1 hreadyout && hresp == RCS_HRESP_OKAY)
        else $error("slave did not answer after exactly one wait state");

endmodule

// >>> include/rcs_pkg.sv
package rcs_pkg;

    // ********************************************************************
    // Counter indices and register layout
    // ********************************************************************

    // Number of statistics counters in the bank.
    localparam int RCS_NCNT = 26;
    // Width of the decoded register address.
    localparam int RCS_AW = 12;

    // Counter indices, in register order.
    localparam int I_V4_NOPAY_F = 0;
    localparam int I_V4_FRAG_F = 1;
    localparam int I_V4_UOFF_F = 2;
    localparam int I_V6_GOOD_F = 3;
    localparam int I_V6_HERR_F = 4;
    localparam int I_V6_NOPAY_F = 5;
    localparam int I_UDP_GOOD_F = 6;
    localparam int I_UDP_ERR_F = 7;
    localparam int I_TCP_GOOD_F = 8;
    localparam int I_TCP_ERR_F = 9;
    localparam int I_ICMP_GOOD_F = 10;
    localparam int I_ICMP_ERR_F = 11;
    localparam int I_V4_GOOD_B = 12;
    localparam int I_V4_HERR_B = 13;
    localparam int I_V4_NOPAY_B = 14;
    localparam int I_V4_FRAG_B = 15;
    localparam int I_V4_UOFF_B = 16;
    localparam int I_V6_GOOD_B = 17;
    localparam int I_V6_HERR_B = 18;
    localparam int I_V6_NOPAY_B = 19;
    localparam int I_UDP_GOOD_B = 20;
    localparam int I_UDP_ERR_B = 21;
    localparam int I_TCP_GOOD_B = 22;
    localparam int I_TCP_ERR_B = 23;
    localparam int I_ICMP_GOOD_B = 24;
    localparam int I_ICMP_ERR_B = 25;

    // Byte offset of each counter, indexed as above.
    localparam logic [RCS_AW-1:0] RCS_CNT_OFS [RCS_NCNT] = '{
        12'h218, 12'h21C, 12'h220, 12'h224, 12'h228, 12'h22C,
        12'h230, 12'h234, 12'h238, 12'h23C, 12'h240, 12'h244,
        12'h250, 12'h254, 12'h258, 12'h25C, 12'h260, 12'h264,
        12'h268, 12'h26C, 12'h270, 12'h274, 12'h278, 12'h27C,
        12'h280, 12'h284};

    // Counter control register and its bit positions.
    localparam logic [RCS_AW-1:0] RCS_CTRL_OFS = 12'h2F0;
    localparam int RCS_CTRL_RESET = 0;
    localparam int RCS_CTRL_STOP_ROLL = 1;
    localparam int RCS_CTRL_RD_CLR = 2;
    localparam int RCS_CTRL_FREEZE = 3;

    // Reset and limit values of a counter.
    localparam logic [31:0] RCS_CNT_RESET = 32'h0000_0000;
    localparam logic [31:0] RCS_CNT_MAX = 32'hFFFF_FFFF;
    // Amount added to a frame counter per frame.
    localparam logic [31:0] RCS_FRAME_INC = 32'h0000_0001;
    // Value answered for unmapped addresses.
    localparam logic [31:0] RCS_RD_ZERO = 32'h0000_0000;
    // Bus encodings used by the slave.
    localparam logic [1:0] RCS_HRESP_OKAY = 2'h0;
    localparam logic [1:0] RCS_BYTE_LANE0 = 2'h0;

    // ********************************************************************
    // Checksum engine result carrier
    // ********************************************************************

    // Transport payload found by the checksum engine.
    typedef enum logic [1:0] {
        RCS_PL_NONE,
        RCS_PL_UDP,
        RCS_PL_TCP,
        RCS_PL_ICMP
    } rcs_payload_t;

    // One received datagram's verdict, valid for a single cycle.
    typedef struct packed {
        logic valid;
        logic is_ipv4;
        logic is_ipv6;
        logic hdr_err;
        logic frag;
        rcs_payload_t payload;
        logic csum_err;
        logic udp_csum_off;
        logic [15:0] ip_len;
        logic [15:0] seg_len;
    } rcs_event_t;

endpackage

// >>> test/rcs_engine_model.sv
`timescale 1ns/10ps
// ********************************************************************
// Checksum engine stand-in
// ********************************************************************
module rcs_engine_model
    import rcs_pkg::*;
(
    // Clock and reset.
    hclk,
    hresetn,
    // Request from the bench.
    go,
    ev_in,
    // Verdict toward the counter bank.
    ce_result
);
    input wire logic hclk;
    input wire logic hresetn;
    input wire logic go;
    input wire rcs_event_t ev_in;
    output rcs_event_t ce_result;

    // A verdict stands for one cycle only.
    // Idle cycles carry a scrambled copy with valid low, so stale fields are never trusted.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ce_result <= '0;
        end else if (go) begin
            ce_result <= rcs_event_t'({1'b1, ev_in[$bits(rcs_event_t)-2:0]});
        end else begin
            ce_result <= rcs_event_t'({1'b0, ~ce_result[$bits(rcs_event_t)-2:0]});
        end
    end
endmodule

// >>> test/tb_rx_ip_checksum_offload_stats.sv
`timescale 1ns/10ps
module tb_rx_ip_checksum_offload_stats;
    import rcs_pkg::*;
    // ********************************************************************
    // Signals and bench state
    // ********************************************************************
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic [31:0] hrdata;
    logic [1:0] hresp;
    logic go = 1'b0;
    rcs_event_t ev_in = '0;
    rcs_event_t ce_result;
    logic [31:0] exp_cnt [RCS_NCNT]; // Expected value of every counter.
    logic [31:0] ctrl = 32'h0000_0000; // Bench copy of the control register.
    int mismatches = 0;
    int check_count = 0;

    // The clock toggles every half period of 10 ns.
    always #10 hclk = ~hclk;

    rcs_stats uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .ce_result(ce_result));
    rcs_engine_model engine (.hclk(hclk), .hresetn(hresetn), .go(go), .ev_in(ev_in),
        .ce_result(ce_result));

    // ********************************************************************
    // Tasks and functions
    // ********************************************************************
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Compares one word and counts the result.
    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
        check_count++;
        if (got !== want) begin
            mismatches++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask

    // One single AHB-Lite transfer; it waits for hready in both phases.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        rd = hrdata;
        chk({30'h0, hresp}, 32'h0000_0000, "response");
        chk(n < 50, 32'h0000_0001, "ready wait");
    endtask

    // Reads one counter; a read with clear-on-read armed empties it.
    task automatic read_cnt(input int i);
        logic [31:0] d;
        bus(1'b0, {20'h0, RCS_CNT_OFS[i]}, 32'h0000_0000, d);
        chk(d, exp_cnt[i], $sformatf("counter %0d", i));
        if (ctrl[RCS_CTRL_RD_CLR]) begin
            exp_cnt[i] = 32'h0000_0000;
        end
    endtask

    // Reads every counter of the bank.
    task automatic check_all();
        for (int i = 0; i < RCS_NCNT; i++) begin
            read_cnt(i);
        end
    endtask

    // Writes the control word; the counter reset bit clears itself.
    task automatic write_ctrl(input logic [31:0] v);
        logic [31:0] d;
        bus(1'b1, {20'h0, RCS_CTRL_OFS}, v, d);
        ctrl = v & 32'hFFFF_FFFE;
        if (v[RCS_CTRL_RESET]) begin
            exp_cnt = '{default: 32'h0000_0000};
        end
    endtask

    // Adds to one counter; with stop-rollover set an overflowing sum sticks at the top.
    function automatic void add1(input int i, input logic [15:0] len);
        logic [32:0] s;
        s = {1'b0, exp_cnt[i]} + {1'b0, 16'h0000, len};
        if (s[32] && ctrl[RCS_CTRL_STOP_ROLL]) begin
            exp_cnt[i] = RCS_CNT_MAX;
        end else begin
            exp_cnt[i] = s[31:0];
        end
    endfunction

    // Adds one frame and a byte count to a pair of counters.
    function automatic void add2(input int f, input int b, input logic [15:0] len);
        add1(f, 16'h0001);
        add1(b, len);
    endfunction

    // Works out which counters one verdict moves.
    function automatic void apply(input rcs_event_t e);
        logic ok;
        logic off;
        int k;
        ok = !e.hdr_err && !e.frag && e.payload != RCS_PL_NONE;
        off = ok && e.is_ipv4 && e.payload == RCS_PL_UDP && e.udp_csum_off;
        if (e.is_ipv4) begin
            if (e.payload == RCS_PL_NONE) add2(I_V4_NOPAY_F, I_V4_NOPAY_B, e.ip_len);
            if (e.frag && !e.hdr_err) add2(I_V4_FRAG_F, I_V4_FRAG_B, e.ip_len);
            if (e.hdr_err) add1(I_V4_HERR_B, e.ip_len);
            if (off) add2(I_V4_UOFF_F, I_V4_UOFF_B, e.seg_len);
            if (ok) add1(I_V4_GOOD_B, e.ip_len);
        end
        if (e.is_ipv6) begin
            if (ok) add2(I_V6_GOOD_F, I_V6_GOOD_B, e.ip_len);
            if (e.hdr_err) add2(I_V6_HERR_F, I_V6_HERR_B, e.ip_len);
            if (e.frag || e.payload == RCS_PL_NONE) begin
                add2(I_V6_NOPAY_F, I_V6_NOPAY_B, e.ip_len);
            end
        end
        if (ok && !off) begin
            k = 2 * (int'(e.payload) - 1) + int'(e.csum_err);
            add2(I_UDP_GOOD_F + k, I_UDP_GOOD_B + k, e.seg_len);
        end
    endfunction

    // Draws a legal verdict at random.
    function automatic rcs_event_t rnd_ev();
        rcs_event_t e;
        e = '0;
        e.valid = 1'b1;
        e.is_ipv4 = 1'($urandom_range(1));
        e.is_ipv6 = !e.is_ipv4;
        e.hdr_err = ($urandom_range(3) == 0);
        e.frag = ($urandom_range(3) == 0);
        e.payload = rcs_payload_t'($urandom_range(3));
        e.csum_err = 1'($urandom_range(1));
        e.udp_csum_off = e.is_ipv4 && e.payload == RCS_PL_UDP && !e.csum_err
            && ($urandom_range(1) == 1);
        e.ip_len = 16'($urandom);
        e.seg_len = 16'($urandom);
        return e;
    endfunction

    // Hands a verdict to the engine model; back-to-back calls give one per cycle.
    task automatic send(input rcs_event_t e);
        go <= 1'b1;
        ev_in <= e;
        @(posedge hclk);
        if (!ctrl[RCS_CTRL_FREEZE]) begin
            apply(e);
        end
    endtask

    // Ends a burst and lets the last verdict land.
    task automatic flush();
        go <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask

    // ********************************************************************
    // Main sequence and watchdog
    // ********************************************************************
    initial begin
        #1700000;
        mismatches++;
        finish_test();
    end

    initial begin
        logic [31:0] d;
        rcs_event_t e;
        exp_cnt = '{default: 32'h0000_0000};
        void'($urandom(76));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check_all();
        bus(1'b1, {20'h0, RCS_CNT_OFS[I_TCP_GOOD_F]}, 32'hFFFF_FFFF, d);
        bus(1'b0, 32'h0000_0248, 32'h0000_0000, d);
        chk(d, RCS_RD_ZERO, "reserved read");
        check_all();
        // Hand-picked corners: checksum-off UDP, maximal length, IPv6 fragment.
        e = '0;
        e.valid = 1'b1;
        e.is_ipv4 = 1'b1;
        e.payload = RCS_PL_UDP;
        e.udp_csum_off = 1'b1;
        e.ip_len = 16'hFFFF;
        e.seg_len = 16'h0008;
        send(e);
        e.udp_csum_off = 1'b0;
        e.csum_err = 1'b1;
        send(e);
        e.is_ipv4 = 1'b0;
        e.is_ipv6 = 1'b1;
        e.frag = 1'b1;
        e.payload = RCS_PL_TCP;
        send(e);
        e.frag = 1'b0;
        e.hdr_err = 1'b1;
        send(e);
        flush();
        check_all();
        repeat (80) send(rnd_ev());
        flush();
        check_all();
        write_ctrl(32'h0000_0008);
        repeat (12) send(rnd_ev());
        flush();
        check_all();
        write_ctrl(32'h0000_0004);
        repeat (20) send(rnd_ev());
        flush();
        check_all();
        check_all();
        write_ctrl(32'h0000_0000);
        repeat (10) send(rnd_ev());
        flush();
        write_ctrl(32'h0000_0001);
        check_all();
        write_ctrl(32'h0000_0002);
        bus(1'b0, {20'h0, RCS_CTRL_OFS}, 32'h0000_0000, d);
        chk(d, 32'h0000_0002, "control read");
        e = '0;
        e.valid = 1'b1;
        e.is_ipv4 = 1'b1;
        e.payload = RCS_PL_TCP;
        e.ip_len = 16'hFFFF;
        e.seg_len = 16'h0001;
        // One full-length datagram more than fits, so the IPv4 byte counter saturates.
        repeat (65538) send(e);
        flush();
        check_all();
        finish_test();
    end
endmodule
